// *** hw/dao_output_ctrl.sv ***
// dual converter output control: apb registers, start-up timing, output pins
// What this block does
// - forwarded clock driven when enable low
// - emit forwarded clock for data capture
// - format 0 offset binary, 1 two's complement
// - power-down forces data, overrange flags, forwarded clock, bias and active outputs zero
// - channel data tristate while its enable high
// - overrange flag high while input out of range
// - bias select off, 50uA, 500uA, 1mA
// - sleep select picks which channels stay active
// - 13-bit or 1Vpp: bit 0 is LSB
// - 2Vpp 12-bit: bit 1 LSB, bit 12 MSB
// - 1Vpp range: bit 11 is MSB
// - 900 input clocks after power-down exit
// - 20 input clocks after sleep exit
// - overrange recovery within one clock
// - rising input clock edge times data and start-up counts; falling edge raises the forwarded clock
module dao_output_ctrl
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire dao_pkg::dao_apb_req_t apb_req,
    output dao_pkg::dao_apb_rsp_t apb_rsp,
    output logic irq,
    input wire logic sample_clk,
    input wire logic [dao_pkg::DATA_W-1:0] chan0_conv_word,
    input wire logic [dao_pkg::DATA_W-1:0] chan1_conv_word,
    input wire logic chan0_conv_over,
    input wire logic chan1_conv_over,
    output dao_pkg::dao_chan_pins_t chan0_pins,
    output dao_pkg::dao_chan_pins_t chan1_pins,
    output logic fwd_output_clock,
    output logic fwd_output_clock_oe,
    output logic [1:0] cm_bias_sel,
    output logic cm_buffer_on,
    output logic [dao_pkg::NUM_CH-1:0] chan_active,
    output logic core_power_on
);
    import dao_pkg::*;

    dao_ctrl_t ctrl_q;
    dao_apb_rsp_t rsp_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_en_q;
    logic irq_q;
    logic [1:0] samp_sync_q;
    logic samp_prev_q;
    logic samp_rise;
    dao_pwr_t pwr_q;
    logic [9:0] pwr_cnt_q;
    logic pwr_ev;
    logic fwd_clk_q;
    logic fwd_oe_q;
    logic [1:0] bias_q;
    logic buf_on_q;
    logic [NUM_CH-1:0] active_q;
    logic core_on_q;
    logic [DATA_W-1:0] conv_word [NUM_CH];
    logic [NUM_CH-1:0] conv_over;
    dao_chan_pins_t pins_q [NUM_CH];
    logic [NUM_CH-1:0] ch_ready_q;
    logic [NUM_CH-1:0] ch_ready_ev;
    logic [NUM_CH-1:0] ovr_ev;
    logic [IRQ_W-1:0] events;
    logic [IRQ_W-1:0] irq_stat_d;
    logic setup_phase;
    logic access_done;
    logic wr_en;
    logic mapped;
    logic [31:0] rd_value;

    assign conv_word[0] = chan0_conv_word;
    assign conv_word[1] = chan1_conv_word;
    assign conv_over = {chan1_conv_over, chan0_conv_over};

    // place and encode one 13-bit conversion for the selected range and format
    function automatic logic [DATA_W-1:0] fmt_sample(
        input logic [DATA_W-1:0] raw,
        input logic twos,
        input logic [1:0] mode
    );
        logic [DATA_W-1:0] w;
        w = raw;
        case (mode)
            // 12-bit word on bits 12..1, bit 0 unused
            RANGE_2VPP: w = {raw[12] ^ twos, raw[11:1], 1'b0};
            // 12-bit word on bits 11..0, bit 12 copies the sign in two's complement, zero in offset binary
            RANGE_1VPP:
            begin
                w[11:0] = raw[12:1];
                w[11] = raw[12] ^ twos;
                w[12] = twos & w[11];
            end
            default: w[12] = raw[12] ^ twos;
        endcase
        return w;
    endfunction

    // apb slave: answer registered in setup, so pready is high in the first access cycle
    assign setup_phase = apb_req.psel && !apb_req.penable;
    assign access_done = apb_req.psel && apb_req.penable && rsp_q.pready;
    assign wr_en = access_done && apb_req.pwrite && !rsp_q.pslverr;

    always_comb
    begin
        mapped = 1'b1;
        rd_value = 32'h0000_0000;
        case (apb_req.paddr)
            REG_CTRL: rd_value = {21'h00_0000, ctrl_q};
            REG_STATUS:
            begin
                rd_value[EV_PWR_READY] = (pwr_q == PWR_ACTIVE);
                rd_value[EV_CH_READY_LSB +: NUM_CH] = ch_ready_q;
                rd_value[EV_OVR_LSB +: NUM_CH] = {pins_q[1].overrange_flag,
                                                  pins_q[0].overrange_flag};
            end
            REG_IRQ_STAT: rd_value[IRQ_W-1:0] = irq_stat_q;
            REG_IRQ_CLR: rd_value = 32'h0000_0000;
            REG_IRQ_EN: rd_value[IRQ_W-1:0] = irq_en_q;
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn || access_done)
            rsp_q <= '0;
        else if (setup_phase)
        begin
            rsp_q.pready <= 1'b1;
            rsp_q.pslverr <= !mapped;
            rsp_q.prdata <= apb_req.pwrite ? 32'h0000_0000 : rd_value;
        end
    end

    // resetn acts as a power-down: control comes up powered down
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            ctrl_q <= dao_ctrl_t'(CTRL_RESET);
        else if (wr_en && apb_req.paddr == REG_CTRL)
            ctrl_q <= dao_ctrl_t'(apb_req.pwdata[CTRL_W-1:0]);
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            irq_en_q <= '0;
        else if (wr_en && apb_req.paddr == REG_IRQ_EN)
            irq_en_q <= apb_req.pwdata[IRQ_W-1:0];
    end

    // sticky events; a new event wins over a clear in the same cycle
    assign events = {ovr_ev, ch_ready_ev, pwr_ev};

    always_comb
    begin
        irq_stat_d = irq_stat_q;
        if (wr_en && apb_req.paddr == REG_IRQ_CLR)
            irq_stat_d = irq_stat_d & ~apb_req.pwdata[IRQ_W-1:0];
        irq_stat_d = irq_stat_d | events;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            irq_stat_q <= '0;
            irq_q <= 1'b0;
        end
        else
        begin
            irq_stat_q <= irq_stat_d;
            irq_q <= |(irq_stat_d & irq_en_q);
        end
    end

    // input clock is sampled; first flop feeds only the second
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            samp_sync_q <= 2'b00;
            samp_prev_q <= 1'b0;
        end
        else
        begin
            samp_sync_q <= {samp_sync_q[0], sample_clk};
            samp_prev_q <= samp_sync_q[1];
        end
    end

    assign samp_rise = samp_sync_q[1] && !samp_prev_q;

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            pwr_q <= PWR_DOWN;
            pwr_cnt_q <= '0;
        end
        else
        begin
            case (pwr_q)
                PWR_DOWN:
                begin
                    pwr_cnt_q <= '0;
                    if (ctrl_q.power_down_n)
                        pwr_q <= PWR_START;
                end
                PWR_START:
                begin
                    if (!ctrl_q.power_down_n)
                        pwr_q <= PWR_DOWN;
                    else if (samp_rise && pwr_cnt_q == PD_LAST)
                        pwr_q <= PWR_ACTIVE;
                    else if (samp_rise)
                        pwr_cnt_q <= pwr_cnt_q + 10'h001;
                end
                PWR_ACTIVE:
                begin
                    if (!ctrl_q.power_down_n)
                        pwr_q <= PWR_DOWN;
                end
                default: pwr_q <= PWR_DOWN;
            endcase
        end
    end

    assign pwr_ev = (pwr_q == PWR_START) && ctrl_q.power_down_n && samp_rise
                    && pwr_cnt_q == PD_LAST;

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++)
        begin : g_chan
            logic [DATA_W-1:0] word_meta_q;
            logic [DATA_W-1:0] word_sync_q;
            logic [1:0] over_sync_q;
            logic [4:0] wake_cnt_q;
            logic chan_on;
            logic chan_valid;

            // word from the converter core is held stable across the sampled edge
            always_ff @(posedge clk_sys)
            begin
                if (!resetn)
                begin
                    word_meta_q <= '0;
                    word_sync_q <= '0;
                    over_sync_q <= 2'b00;
                end
                else
                begin
                    word_meta_q <= conv_word[ch];
                    word_sync_q <= word_meta_q;
                    over_sync_q <= {over_sync_q[0], conv_over[ch]};
                end
            end

            assign chan_on = ctrl_q.sleep_n[ch] && (pwr_q != PWR_DOWN);
            assign chan_valid = ch_ready_q[ch] && (pwr_q == PWR_ACTIVE);

            // wake count, runs alongside the power-up count
            always_ff @(posedge clk_sys)
            begin
                if (!resetn || !chan_on)
                begin
                    wake_cnt_q <= '0;
                    ch_ready_q[ch] <= 1'b0;
                end
                else if (samp_rise && !ch_ready_q[ch])
                begin
                    if (wake_cnt_q == SLP_LAST)
                        ch_ready_q[ch] <= 1'b1;
                    else
                        wake_cnt_q <= wake_cnt_q + 5'h01;
                end
            end

            assign ch_ready_ev[ch] = chan_on && samp_rise && !ch_ready_q[ch]
                                     && wake_cnt_q == SLP_LAST;
            assign ovr_ev[ch] = samp_rise && chan_valid && over_sync_q[1]
                                && !pins_q[ch].overrange_flag;

            always_ff @(posedge clk_sys)
            begin
                if (!resetn)
                    pins_q[ch] <= '0;
                else
                begin
                    pins_q[ch].data_oe <= {DATA_W{!ctrl_q.out_enable_n[ch]}};
                    if (pwr_q == PWR_DOWN)
                    begin
                        pins_q[ch].data <= '0;
                        pins_q[ch].overrange_flag <= 1'b0;
                    end
                    else if (samp_rise)
                    begin
                        pins_q[ch].data <= chan_valid
                            ? fmt_sample(word_sync_q, ctrl_q.format_select, ctrl_q.range_mode)
                            : '0;
                        pins_q[ch].overrange_flag <= chan_valid && over_sync_q[1];
                    end
                end
            end
        end
    endgenerate

    // forwarded clock falls as data changes, rises mid-sample for capture
    always_ff @(posedge clk_sys)
    begin
        if (!resetn || pwr_q == PWR_DOWN)
            fwd_clk_q <= 1'b0;
        else
            fwd_clk_q <= !samp_sync_q[1];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            fwd_oe_q <= 1'b0;
        else
            fwd_oe_q <= !ctrl_q.fwd_clock_enable_n;
    end

    // bias select to the common-mode buffer
    always_ff @(posedge clk_sys)
    begin
        if (!resetn || pwr_q == PWR_DOWN)
        begin
            bias_q <= 2'b00;
            buf_on_q <= 1'b0;
            active_q <= '0;
            core_on_q <= 1'b0;
        end
        else
        begin
            bias_q <= ctrl_q.cm_bias_sel;
            buf_on_q <= (dao_bias_t'(ctrl_q.cm_bias_sel) != BIAS_OFF);
            active_q <= ctrl_q.sleep_n;
            core_on_q <= 1'b1;
        end
    end

    assign apb_rsp = rsp_q;
    assign irq = irq_q;
    assign chan0_pins = pins_q[0];
    assign chan1_pins = pins_q[1];
    assign fwd_output_clock = fwd_clk_q;
    assign fwd_output_clock_oe = fwd_oe_q;
    assign cm_bias_sel = bias_q;
    assign cm_buffer_on = buf_on_q;
    assign chan_active = active_q;
    assign core_power_on = core_on_q;

endmodule // dao_output_ctrl

// *** shared/dao_pkg.sv ***
// constants, register map and carrier types of the dual converter output control
package dao_pkg;

    localparam int DATA_W = 13;
    localparam int NUM_CH = 2;
    localparam int APB_ADDR_W = 12;
    localparam int IRQ_W = 5;

    // register byte addresses
    localparam logic [APB_ADDR_W-1:0] REG_CTRL = 12'h000;
    localparam logic [APB_ADDR_W-1:0] REG_STATUS = 12'h004;
    localparam logic [APB_ADDR_W-1:0] REG_IRQ_STAT = 12'h008;
    localparam logic [APB_ADDR_W-1:0] REG_IRQ_CLR = 12'h00C;
    localparam logic [APB_ADDR_W-1:0] REG_IRQ_EN = 12'h010;

    // event bit positions in status, clear and enable registers
    localparam int EV_PWR_READY = 0;
    localparam int EV_CH_READY_LSB = 1;
    localparam int EV_OVR_LSB = 3;

    // start-up times in input clock cycles
    localparam int PD_START_CYCLES = 900;
    localparam int SLP_START_CYCLES = 20;
    localparam logic [9:0] PD_LAST = 10'(PD_START_CYCLES - 1);
    localparam logic [4:0] SLP_LAST = 5'(SLP_START_CYCLES - 1);

    typedef enum logic [1:0] {
        RANGE_13BIT = 2'b00,
        RANGE_2VPP = 2'b01,
        RANGE_1VPP = 2'b10
    } dao_range_t;

    typedef enum logic [1:0] {
        BIAS_OFF = 2'b00,
        BIAS_50UA = 2'b01,
        BIAS_500UA = 2'b10,
        BIAS_1MA = 2'b11
    } dao_bias_t;

    typedef enum logic [1:0] {
        PWR_DOWN = 2'b00,
        PWR_START = 2'b01,
        PWR_ACTIVE = 2'b10
    } dao_pwr_t;

    // control register, bit 0 at the bottom
    typedef struct packed {
        logic [1:0] range_mode;
        logic [1:0] out_enable_n;
        logic fwd_clock_enable_n;
        logic [1:0] cm_bias_sel;
        logic [1:0] sleep_n;
        logic format_select;
        logic power_down_n;
    } dao_ctrl_t;

    localparam int CTRL_W = 11;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h1CC;

    typedef struct packed {
        logic [APB_ADDR_W-1:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } dao_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } dao_apb_rsp_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [DATA_W-1:0] data_oe;
        logic overrange_flag;
    } dao_chan_pins_t;

endpackage

// *** verification/dao_capture_model.sv ***
// capture logic beside the converter outputs
module dao_capture_model
(
    input wire logic fwd_output_clock,
    input wire logic fwd_output_clock_oe,
    input wire dao_pkg::dao_chan_pins_t chan0_pins,
    input wire dao_pkg::dao_chan_pins_t chan1_pins,
    output logic [dao_pkg::DATA_W-1:0] cap0,
    output logic [dao_pkg::DATA_W-1:0] cap1,
    output logic flag0,
    output logic flag1
);
    timeunit 1ns;
    timeprecision 1ps;
    import dao_pkg::*;
    initial
    begin
        cap0 = '0;
        cap1 = '0;
        flag0 = 1'b0;
        flag1 = 1'b0;
    end
    always @(posedge fwd_output_clock)
    begin
        if (fwd_output_clock_oe)
        begin
            cap0 <= (chan0_pins.data & chan0_pins.data_oe) | (~cap0 & ~chan0_pins.data_oe);
            cap1 <= (chan1_pins.data & chan1_pins.data_oe) | (~cap1 & ~chan1_pins.data_oe);
            flag0 <= chan0_pins.overrange_flag;
            flag1 <= chan1_pins.overrange_flag;
        end
    end
endmodule // dao_capture_model

// *** verification/dao_output_ctrl_assertions.sv ***
// concurrent checks on the output control ports
module dao_output_ctrl_assertions
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire dao_pkg::dao_apb_req_t apb_req,
    input wire dao_pkg::dao_apb_rsp_t apb_rsp,
    input wire logic sample_clk,
    input wire dao_pkg::dao_chan_pins_t chan0_pins,
    input wire dao_pkg::dao_chan_pins_t chan1_pins,
    input wire logic fwd_output_clock,
    input wire logic [1:0] cm_bias_sel,
    input wire logic cm_buffer_on,
    input wire logic [dao_pkg::NUM_CH-1:0] chan_active,
    input wire logic core_power_on
);
    timeunit 1ns;
    timeprecision 1ps;
    import dao_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // fwd clock high at the rise, so a fall must follow
    sequence s_rise; $rose(sample_clk) && core_power_on && fwd_output_clock; endsequence
    sequence s_fall; $fell(fwd_output_clock); endsequence
    property p_fwd_follows; s_rise |-> ##[1:4] s_fall; endproperty
    a_fwd_follows: assert property (p_fwd_follows) else $error("no fwd fall");
    property p_fwd_low; s_fall |=> !fwd_output_clock [*2]; endproperty
    a_fwd_low: assert property (p_fwd_low) else $error("fwd low too short");
    property p_fwd_run; $rose(fwd_output_clock) |-> core_power_on; endproperty
    a_fwd_run: assert property (p_fwd_run) else $error("fwd clock in power-down");
    property p_flag_pair; ($changed(chan0_pins.overrange_flag)
        || $changed(chan1_pins.overrange_flag)) && core_power_on && $past(core_power_on)
        |-> s_fall; endproperty
    a_flag_pair: assert property (p_flag_pair) else $error("flag off data edge");
    property p_pd_quiet; !core_power_on && !$past(core_power_on) && !$past(core_power_on, 2)
        |-> chan0_pins.data == '0 && chan1_pins.data == '0 && !chan0_pins.overrange_flag
        && !chan1_pins.overrange_flag && chan_active == '0 && cm_bias_sel == 2'b00
        && !fwd_output_clock;
    endproperty
    a_pd_quiet: assert property (p_pd_quiet) else $error("output live in power-down");
    property p_bias_on; cm_buffer_on == (cm_bias_sel != 2'b00); endproperty
    a_bias_on: assert property (p_bias_on) else $error("buffer state wrong");
    property p_oe_whole; chan0_pins.data_oe inside {13'h0000, 13'h1FFF}
        && chan1_pins.data_oe inside {13'h0000, 13'h1FFF}; endproperty
    a_oe_whole: assert property (p_oe_whole) else $error("partial data enable");
    property p_act_pwr; chan_active != 2'b00 |-> core_power_on; endproperty
    a_act_pwr: assert property (p_act_pwr) else $error("channel on in power-down");
    property p_apb_ready; apb_req.psel && !apb_req.penable |=> apb_rsp.pready; endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("no ready in access");
    property p_apb_only; apb_rsp.pready |-> apb_req.psel && apb_req.penable; endproperty
    a_apb_only: assert property (p_apb_only) else $error("ready outside access");
endmodule // dao_output_ctrl_assertions

bind dao_output_ctrl dao_output_ctrl_assertions dao_output_ctrl_assertions_i (.clk_sys, .resetn,
    .apb_req, .apb_rsp, .sample_clk, .chan0_pins, .chan1_pins, .fwd_output_clock, .cm_bias_sel,
    .cm_buffer_on, .chan_active, .core_power_on);

// *** verification/tb_top.sv ***
// testbench of the dual converter output control
`define CHK(a, b, m) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
    $display("CHECK FAILED %0t %s", $time, m); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dao_pkg::*;
    localparam logic [12:0] W0 = 13'h1A5C;
    localparam logic [12:0] W1 = 13'h0123;
    logic clk_sys, resetn, sample_clk, irq, fwd_output_clock, fwd_output_clock_oe;
    logic chan0_conv_over, chan1_conv_over, cm_buffer_on, core_power_on, flag0, flag1, e;
    logic [DATA_W-1:0] chan0_conv_word, chan1_conv_word, cap0, cap1;
    logic [1:0] cm_bias_sel, chan_active;
    logic [31:0] r;
    dao_apb_req_t apb_req;
    dao_apb_rsp_t apb_rsp;
    dao_chan_pins_t chan0_pins, chan1_pins;
    dao_ctrl_t c;
    int n_mismatch = 0;
    int samples_checked = 0;

    dao_output_ctrl dao_output_ctrl_i (.clk_sys, .resetn, .apb_req, .apb_rsp, .irq, .sample_clk,
        .chan0_conv_word, .chan1_conv_word, .chan0_conv_over, .chan1_conv_over, .chan0_pins,
        .chan1_pins, .fwd_output_clock, .fwd_output_clock_oe, .cm_bias_sel, .cm_buffer_on,
        .chan_active, .core_power_on);
    dao_capture_model dao_capture_model_i (.fwd_output_clock, .fwd_output_clock_oe, .chan0_pins,
        .chan1_pins, .cap0, .cap1, .flag0, .flag1);

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // odd offset keeps the converter clock unrelated in phase
    initial
    begin
        sample_clk = 1'b0;
        #7;
        forever #40 sample_clk = ~sample_clk;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic wait_clk(int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // let the synchroniser and output register settle after the rises
    task automatic rises(int n);
        repeat (n) @(posedge sample_clk);
        wait_clk(8);
    endtask

    task automatic apb(logic [11:0] a, logic w, logic [31:0] d);
        int k;
        @(posedge clk_sys);
        apb_req <= '{a, 1'b1, 1'b0, w, d};
        @(posedge clk_sys);
        apb_req.penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (apb_rsp.pready !== 1'b1 && k < 20);
        if (apb_rsp.pready !== 1'b1)
        begin
            n_mismatch++;
            wrap_up();
        end
        r = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic t_start();
        apb(REG_CTRL, 1'b0, 32'h0);
        `CHK(r, 32'h000001CC, "ctrl reset")
        `CHK(chan0_pins.data, 13'h0000, "data at reset")
        c = dao_ctrl_t'(CTRL_RESET);
        c.power_down_n = 1'b1;
        c.out_enable_n = 2'b00;
        c.fwd_clock_enable_n = 1'b0;
        apb(REG_CTRL, 1'b1, 32'(c));
        rises(880);
        `CHK(chan0_pins.data, 13'h0000, "early data")
        rises(30);
        `CHK(cap0, W0, "chan0 word")
        `CHK(cap1, W1, "chan1 word")
        $display("test start done");
    endtask

    task automatic t_modes();
        for (int i = 0; i < 4; i++)
        begin
            c.sleep_n = 2'(i);
            c.cm_bias_sel = 2'(i);
            apb(REG_CTRL, 1'b1, 32'(c));
            wait_clk(3);
            `CHK(chan_active, 2'(i), "sleep code")
            `CHK(cm_bias_sel, 2'(i), "bias code")
            `CHK(cm_buffer_on, i != 0, "buffer on")
        end
        rises(15);
        `CHK(chan1_pins.data, 13'h0000, "chan1 waking")
        rises(10);
        `CHK(cap1, W1, "chan1 awake")
        $display("test modes done");
    endtask

    task automatic t_format();
        logic [12:0] x;
        for (int f = 0; f < 2; f++)
            for (int m = 0; m < 4; m++)
            begin
                c.format_select = f[0];
                c.range_mode = 2'(m);
                apb(REG_CTRL, 1'b1, 32'(c));
                rises(3);
                x = f[0] ? W0 ^ 13'h1000 : W0;
                if (m == 0 || m == 3) `CHK(cap0, x, "13-bit format")
                if (m == 1) `CHK(cap0[12:1], x[12:1], "2Vpp place")
                if (m == 2) `CHK(cap0, {f[0] & x[12], x[12:1]}, "1Vpp place")
            end
        c.format_select = 1'b0;
        c.range_mode = 2'b00;
        c.out_enable_n = 2'b01;
        c.fwd_clock_enable_n = 1'b1;
        apb(REG_CTRL, 1'b1, 32'(c));
        wait_clk(3);
        `CHK(chan0_pins.data_oe, 13'h0000, "chan0 off")
        `CHK(chan1_pins.data_oe, 13'h1FFF, "chan1 on")
        `CHK(fwd_output_clock_oe, 1'b0, "fwd off")
        c.out_enable_n = 2'b00;
        c.fwd_clock_enable_n = 1'b0;
        apb(REG_CTRL, 1'b1, 32'(c));
        wait_clk(3);
        `CHK(fwd_output_clock_oe, 1'b1, "fwd on")
        $display("test format done");
    endtask

    task automatic t_ovr();
        apb(REG_IRQ_CLR, 1'b1, 32'h1F);
        apb(REG_IRQ_EN, 1'b1, 32'h08);
        chan1_conv_over <= 1'b1;
        rises(3);
        `CHK(flag1, 1'b1, "chan1 flag")
        `CHK(irq, 1'b0, "masked irq")
        chan0_conv_over <= 1'b1;
        rises(3);
        `CHK(chan0_pins.overrange_flag, 1'b1, "chan0 flag")
        `CHK(irq, 1'b1, "irq up")
        apb(REG_STATUS, 1'b0, 32'h0);
        `CHK(r, 32'h0000001F, "status flags")
        apb(REG_IRQ_STAT, 1'b0, 32'h0);
        `CHK(r, 32'h00000018, "sticky overrange")
        chan0_conv_over <= 1'b0;
        chan1_conv_over <= 1'b0;
        rises(2);
        `CHK(flag0, 1'b0, "chan0 recovered")
        apb(REG_IRQ_CLR, 1'b1, 32'h1F);
        wait_clk(2);
        `CHK(irq, 1'b0, "irq cleared")
        apb(12'h020, 1'b0, 32'h0);
        `CHK(e, 1'b1, "unmapped error")
        c.power_down_n = 1'b0;
        apb(REG_CTRL, 1'b1, 32'(c));
        wait_clk(3);
        `CHK(core_power_on, 1'b0, "powered down")
        `CHK(chan0_pins.data, 13'h0000, "data zero")
        $display("test overrange done");
    endtask

    initial
    begin
        apb_req = '0;
        resetn = 1'b0;
        chan0_conv_word = W0;
        chan1_conv_word = W1;
        chan0_conv_over = 1'b0;
        chan1_conv_over = 1'b0;
        wait_clk(12);
        resetn <= 1'b1;
        t_start();
        t_modes();
        t_format();
        t_ovr();
        wrap_up();
    end
endmodule // tb_top
